// ===== verilog/isp_pkg.sv
// Purpose: Shared constants for the flash self-program sequencer.
// Assumes: Avalon-MM register slave with 32-bit data, one word per register.
// Notes:   Printed offsets step by one, not by four, so they are indices.
package isp_pkg;
  localparam int          CLK_HZ          = 25000000;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  IDX_COMMAND     = 8'h94;
  localparam logic [7:0]  IDX_ADDR_LOW    = 8'h95;
  localparam logic [7:0]  IDX_ADDR_HIGH   = 8'h96;
  localparam logic [7:0]  IDX_RAM_PTR     = 8'h97;
  localparam logic [7:0]  IDX_STATUS      = 8'h98;
  localparam logic [7:0]  CMD_PAGE        = 8'h5a;
  localparam logic [7:0]  CMD_BYTE        = 8'h1e;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam int          PAGE_BYTES      = 32;
  localparam int          PAGE_LSB        = 5;
  localparam int          FLASH_BYTES     = 4096;
  localparam int          FLASH_AW        = 12;
  localparam logic [4:0]  LAST_OFFSET     = 5'h1f;
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_ERR_BIT    = 1;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAM_RD,
    ST_FL_WR,
    ST_FL_WAIT
  } seq_state_t;
endpackage : isp_pkg

// ===== verilog/isp_regs.sv
// Purpose: Avalon-MM register file of the flash self-program sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   A write to the command register issues a one-cycle command pulse.
`timescale 1ns/1ns
module isp_regs
  import isp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [1:0]        status,
  input  wire logic              busy,
  output logic [7:0]             ram_buffer_pointer,
  output logic [15:0]            flash_target_address,
  output logic                   cmd_valid,
  output logic [7:0]             cmd_code
);
  typedef struct packed {
    logic [7:0]  ptr;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic        cmd_v;
    logic [7:0]  cmd;
    logic [31:0] rdata;
    logic        ack;
  } regs_t;

  regs_t cur_ff;
  regs_t nxt_cur;
  logic  wr_lane0;

  assign wr_lane0 = avs_write && avs_byteenable[0];

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.cmd_v = 1'b0;
    nxt_cur.ack   = 1'b0;
    // Register reads and writes are held off while a program runs; waitrequest stays high.
    if ((avs_read || avs_write) && !cur_ff.ack && !busy) begin
      nxt_cur.ack   = 1'b1;
      nxt_cur.rdata = 32'h0000_0000;
      if (wr_lane0) begin
        unique case (avs_address)
          IDX_RAM_PTR:   nxt_cur.ptr = avs_writedata[7:0];
          IDX_ADDR_LOW:  nxt_cur.lo  = avs_writedata[7:0];
          IDX_ADDR_HIGH: nxt_cur.hi  = avs_writedata[7:0];
          IDX_COMMAND: begin
            nxt_cur.cmd_v = 1'b1;
            nxt_cur.cmd   = avs_writedata[7:0];
          end
          default: ;
        endcase
      end
      if (avs_read) begin
        unique case (avs_address)
          IDX_RAM_PTR:   nxt_cur.rdata = {24'h000000, cur_ff.ptr};
          IDX_ADDR_LOW:  nxt_cur.rdata = {24'h000000, cur_ff.lo};
          IDX_ADDR_HIGH: nxt_cur.rdata = {24'h000000, cur_ff.hi};
          IDX_STATUS:    nxt_cur.rdata = {30'h00000000, status};
          default:       nxt_cur.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign avs_waitrequest      = (avs_read || avs_write) && !cur_ff.ack;
  assign avs_readdata         = cur_ff.rdata;
  assign ram_buffer_pointer   = cur_ff.ptr;
  assign flash_target_address = {cur_ff.hi, cur_ff.lo};
  assign cmd_valid            = cur_ff.cmd_v;
  assign cmd_code             = cur_ff.cmd;
endmodule : isp_regs

// ===== verilog/flash_self_program_sequencer.sv
// Purpose: Copies data RAM bytes into the program flash on a firmware command.
// Assumes: RAM read data arrives one cycle after the read strobe; flash
//          signals done with a one-cycle pulse after each byte write strobe.
// Notes:   Operation
// Operation
// - Page program sources 32 bytes from internal data RAM.
// - Flash pages start on addresses with five low bits zero.
// - 8-bit register holds the RAM source buffer start address.
// - 16-bit flash target split into high and low 8-bit registers.
// - Command 0x5A starts page program copying 32 RAM bytes.
// - Byte program reads exactly one byte at the buffer pointer.
// - Command 0x1E stores one RAM byte at the target address.
// - Command register write-only; status read-only; others read-write; all reset zero.
// - Flash holds 4 KB as 128 pages of 32 bytes.
`timescale 1ns/1ns
module flash_self_program_sequencer
  import isp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  output logic                     ram_rd,
  output logic [7:0]               ram_addr,
  input  wire logic [7:0]          ram_rdata,
  output logic                     flash_wr,
  output logic [FLASH_AW-1:0]      flash_addr,
  output logic [7:0]               flash_wdata,
  input  wire logic                flash_done,
  output logic                     fetch_stall
);
  typedef struct packed {
    seq_state_t             st;
    logic                   page;
    logic [4:0]             cnt;
    logic [7:0]             rptr;
    logic [FLASH_AW-1:0]    faddr;
    logic [7:0]             data;
    logic                   wr;
    logic                   rd;
    logic                   err;
  } seq_t;

  seq_t        cur_ff;
  seq_t        nxt_cur;
  logic [7:0]  ptr;
  logic [15:0] tgt;
  logic        cmd_v;
  logic [7:0]  cmd;
  logic        busy;

  isp_regs u_regs (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_writedata        (avs_writedata),
    .avs_byteenable       (avs_byteenable),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .status               ({cur_ff.err, busy}),
    .busy                 (busy),
    .ram_buffer_pointer   (ptr),
    .flash_target_address (tgt),
    .cmd_valid            (cmd_v),
    .cmd_code             (cmd)
  );

  // Flash page base with the in-page offset cleared.
  function automatic logic [FLASH_AW-1:0] page_base(input logic [15:0] a);
    page_base = {a[FLASH_AW-1:PAGE_LSB], 5'h00};
  endfunction : page_base

  // True for the two programming codes; every other code is reserved.
  function automatic logic is_prog_cmd(input logic [7:0] c);
    is_prog_cmd = (c == CMD_PAGE) || (c == CMD_BYTE);
  endfunction : is_prog_cmd

  assign busy = (cur_ff.st != ST_IDLE);

  always_comb begin
    nxt_cur    = cur_ff;
    nxt_cur.wr = 1'b0;
    nxt_cur.rd = 1'b0;
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (cmd_v) begin
          nxt_cur.rptr = ptr;
          nxt_cur.cnt  = 5'h00;
          if (cmd == CMD_PAGE) begin
            nxt_cur.page  = 1'b1;
            nxt_cur.faddr = page_base(tgt);
            nxt_cur.st    = ST_RAM_RD;
            nxt_cur.rd    = 1'b1;
            nxt_cur.err   = 1'b0;
          end else if (cmd == CMD_BYTE) begin
            nxt_cur.page  = 1'b0;
            nxt_cur.faddr = tgt[FLASH_AW-1:0];
            nxt_cur.st    = ST_RAM_RD;
            nxt_cur.rd    = 1'b1;
            nxt_cur.err   = 1'b0;
          end else begin
            // Reserved codes start nothing and are flagged in status.
            nxt_cur.err = 1'b1;
          end
        end
      end
      ST_RAM_RD: begin
        nxt_cur.st = ST_FL_WR;
      end
      ST_FL_WR: begin
        nxt_cur.data = ram_rdata;
        nxt_cur.wr   = 1'b1;
        nxt_cur.st   = ST_FL_WAIT;
      end
      ST_FL_WAIT: begin
        if (flash_done) begin
          if (cur_ff.page && (cur_ff.cnt != LAST_OFFSET)) begin
            nxt_cur.cnt   = cur_ff.cnt + 5'h01;
            nxt_cur.rptr  = cur_ff.rptr + 8'h01;
            nxt_cur.faddr = cur_ff.faddr + 12'h001;
            nxt_cur.rd    = 1'b1;
            nxt_cur.st    = ST_RAM_RD;
          end else begin
            nxt_cur.st = ST_IDLE;
          end
        end
      end
      default: nxt_cur.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign ram_rd      = cur_ff.rd;
  assign ram_addr    = cur_ff.rptr;
  assign flash_wr    = cur_ff.wr;
  assign flash_addr  = cur_ff.faddr;
  assign flash_wdata = cur_ff.data;
  assign fetch_stall = busy || cmd_v;

  sequence s_page_cmd;
    cmd_v && (cmd == CMD_PAGE) && !busy;
  endsequence

  sequence s_byte_cmd;
    cmd_v && (cmd == CMD_BYTE) && !busy;
  endsequence

  // Timing of one byte, counted from the command pulse in cycle c0:
  // c1 carries the RAM read strobe with the pointer on ram_addr,
  // c2 is the cycle in which the RAM answers, c3 carries the flash write
  // strobe with address and data, and the sequencer then waits for done.
  // A page repeats this 32 times with the pointer and the flash offset
  // stepping by one; a byte program runs it once.
  // The checks below hold each of those steps, the hold of address and
  // data while the array writes, and the bus stall seen by the CPU.

  sequence s_prog_cmd;
    cmd_v && is_prog_cmd(cmd) && !busy;
  endsequence

  sequence s_bad_cmd;
    cmd_v && !is_prog_cmd(cmd) && !busy;
  endsequence

  sequence s_ram_fetch;
    ram_rd && busy;
  endsequence

  sequence s_byte_done;
    flash_done && busy && (cur_ff.st == ST_FL_WAIT);
  endsequence

  a_page_start_rd: assert property (@(posedge clk) disable iff (sys_rst)
    s_page_cmd |=> ram_rd && ram_addr == $past(ptr))
    else $error("page command did not read RAM at the pointer");

  a_page_aligned: assert property (@(posedge clk) disable iff (sys_rst)
    s_page_cmd |=> flash_addr[4:0] == 5'h00)
    else $error("page program not aligned");

  a_byte_addr: assert property (@(posedge clk) disable iff (sys_rst)
    s_byte_cmd |=> flash_addr == $past(tgt[FLASH_AW-1:0]) && !cur_ff.page)
    else $error("byte program address wrong");

  a_write_data: assert property (@(posedge clk) disable iff (sys_rst)
    ram_rd |-> ##2 flash_wr && flash_wdata == $past(ram_rdata))
    else $error("flash data not the RAM byte");

  a_stall_busy: assert property (@(posedge clk) disable iff (sys_rst)
    s_prog_cmd |=> busy && fetch_stall)
    else $error("fetch not stalled while programming");

  a_page_step: assert property (@(posedge clk) disable iff (sys_rst)
    flash_done && cur_ff.page && cur_ff.cnt != LAST_OFFSET && busy
      |=> flash_addr == $past(flash_addr) + 12'h001)
    else $error("page offset did not advance");

  a_page_end: assert property (@(posedge clk) disable iff (sys_rst)
    flash_done && cur_ff.page && cur_ff.cnt == LAST_OFFSET |=> !busy)
    else $error("page program not 32 bytes");

  a_byte_single: assert property (@(posedge clk) disable iff (sys_rst)
    flash_done && !cur_ff.page && busy |=> !busy)
    else $error("byte program wrote more than one byte");

  a_reg_reset: assert property (@(posedge clk)
    $past(sys_rst) |-> ptr == REG_RESET && tgt == 16'h0000)
    else $error("registers not zero after reset");

  a_pointer_rd: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && avs_address == IDX_RAM_PTR
      |-> avs_readdata[7:0] == ptr)
    else $error("pointer readback wrong");

  a_bus_held: assert property (@(posedge clk) disable iff (sys_rst)
    busy && (avs_read || avs_write)
      |-> avs_waitrequest)
    else $error("bus access answered while programming");

  a_bad_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    s_bad_cmd
      |=> !busy && !ram_rd)
    else $error("reserved command started a program");

  a_err_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_bad_cmd
      |=> cur_ff.err)
    else $error("reserved command not flagged");

  a_err_clear: assert property (@(posedge clk) disable iff (sys_rst)
    s_prog_cmd
      |=> !cur_ff.err)
    else $error("error flag not cleared by a valid command");

  a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !busy && !cmd_v
      |-> !ram_rd && !flash_wr)
    else $error("strobe while idle");

  a_rd_to_wr: assert property (@(posedge clk) disable iff (sys_rst)
    s_ram_fetch
      |=> !flash_wr ##1 flash_wr)
    else $error("flash write not two cycles after RAM read");

  a_wr_one_shot: assert property (@(posedge clk) disable iff (sys_rst)
    flash_wr
      |=> !flash_wr)
    else $error("flash write strobe longer than one cycle");

  a_rd_one_shot: assert property (@(posedge clk) disable iff (sys_rst)
    ram_rd
      |=> !ram_rd)
    else $error("RAM read strobe longer than one cycle");

  a_addr_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (cur_ff.st == ST_FL_WAIT) && !flash_done
      |=> $stable(flash_addr))
    else $error("flash address moved during a write");

  a_data_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (cur_ff.st == ST_FL_WAIT) && !flash_done
      |=> $stable(flash_wdata))
    else $error("flash data moved during a write");

  a_ptr_step: assert property (@(posedge clk) disable iff (sys_rst)
    s_byte_done ##0 (cur_ff.page && (cur_ff.cnt != LAST_OFFSET))
      |=> ram_rd && (ram_addr == $past(ram_addr) + 8'h01))
    else $error("RAM pointer did not step by one");

  a_first_offset: assert property (@(posedge clk) disable iff (sys_rst)
    s_page_cmd
      |=> cur_ff.cnt == 5'h00 && flash_addr == {$past(tgt[FLASH_AW-1:PAGE_LSB]), 5'h00})
    else $error("page program did not start at offset zero");

  a_byte_ptr: assert property (@(posedge clk) disable iff (sys_rst)
    s_byte_cmd
      |=> ram_rd && ram_addr == $past(ptr))
    else $error("byte program did not read RAM at the pointer");

  a_page_flag: assert property (@(posedge clk) disable iff (sys_rst)
    s_page_cmd
      |=> cur_ff.page && busy)
    else $error("page command did not start a page program");

  a_wait_state: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(avs_read) && !busy
      |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait state");

  a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  a_cmd_readback: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && (avs_address == IDX_COMMAND)
      |-> avs_readdata[7:0] == REG_RESET)
    else $error("command register not write-only");

  a_lo_readback: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && (avs_address == IDX_ADDR_LOW)
      |-> avs_readdata[7:0] == tgt[7:0])
    else $error("target low readback wrong");

  a_hi_readback: assert property (@(posedge clk) disable iff (sys_rst)
    avs_read && !avs_waitrequest && (avs_address == IDX_ADDR_HIGH)
      |-> avs_readdata[7:0] == tgt[15:8])
    else $error("target high readback wrong");

  a_lo_write: assert property (@(posedge clk) disable iff (sys_rst)
    avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address == IDX_ADDR_LOW)
      |-> tgt[7:0] == avs_writedata[7:0])
    else $error("target low write lost");

  a_hi_write: assert property (@(posedge clk) disable iff (sys_rst)
    avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address == IDX_ADDR_HIGH)
      |-> tgt[15:8] == avs_writedata[7:0])
    else $error("target high write lost");

  a_ptr_write: assert property (@(posedge clk) disable iff (sys_rst)
    avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address == IDX_RAM_PTR)
      |-> ptr == avs_writedata[7:0])
    else $error("pointer write lost");
endmodule : flash_self_program_sequencer

// ===== sim/flash_partner.sv
// Purpose: Data RAM and program flash array on the far side of the sequencer.
// Assumes: RAM data is valid from one to four cycles after the read strobe.
// Notes:   Stale RAM data toggles every cycle; done pulses lag plus one cycles after a write.
`timescale 1ns/1ns
module flash_partner (
  input  wire logic        clk,
  input  wire logic        ram_rd,
  input  wire logic [7:0]  ram_addr,
  output logic      [7:0]  ram_rdata,
  input  wire logic        flash_wr,
  input  wire logic [11:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  output logic             flash_done,
  input  wire logic [3:0]  lag
);
  logic [7:0] ram   [256];
  logic [7:0] flash [4096];
  logic [3:0] hold_ff;
  logic [3:0] cnt_ff;
  initial begin
    ram_rdata = 8'h00;
    flash_done = 1'b0;
    hold_ff = 4'h0;
    cnt_ff = 4'h0;
    for (int i = 0; i < 4096; i++) flash[i] = 8'hff;
  end
  always @(posedge clk) begin
    flash_done <= 1'b0;
    if (ram_rd === 1'b1) begin
      ram_rdata <= ram[ram_addr];
      hold_ff   <= 4'h3;
    end else if (hold_ff != 4'h0) hold_ff <= hold_ff - 4'h1;
    else ram_rdata <= ~ram_rdata;
    if (flash_wr === 1'b1) begin
      flash[flash_addr] <= flash_wdata;
      cnt_ff            <= lag;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff     <= cnt_ff - 4'h1;
      flash_done <= (cnt_ff == 4'h1);
    end
  end
endmodule : flash_partner

// ===== sim/flash_self_program_sequencer_test.sv
// Purpose: Self-checking bench for the flash self-program sequencer.
// Assumes: Firmware role is played by the bus tasks and direct RAM fills.
// Notes:   Each scenario is a task; the watchdog ends a hung run.
`timescale 1ns/1ns
module flash_self_program_sequencer_test;
  import isp_pkg::*;
  logic                clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic                ram_rd, flash_wr, flash_done, fetch_stall;
  logic [7:0]          avs_address, ram_addr, ram_rdata, flash_wdata, rd_val;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable, lag;
  logic [FLASH_AW-1:0] flash_addr;
  logic [FLASH_AW-1:0] wr_log [64];
  int                  errors, samples_checked, nwr;

  flash_self_program_sequencer i_flash_self_program_sequencer (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ram_rd(ram_rd),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .flash_wr(flash_wr),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_done(flash_done),
    .fetch_stall(fetch_stall));
  flash_partner i_flash_partner (
    .clk(clk), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
    .flash_wr(flash_wr), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done), .lag(lag));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (flash_wr === 1'b1) begin
    wr_log[nwr[5:0]] <= flash_addr;
    nwr <= nwr + 1;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 3000) begin
      n++;
      @(posedge clk);
    end
    rd_val = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 3000) begin
      errors++;
      $display("[ERR] %0t bus hang", $time);
    end
  endtask : bus

  task automatic t_reset;
    logic [7:0] idx [5];
    idx = '{IDX_COMMAND, IDX_ADDR_LOW, IDX_ADDR_HIGH, IDX_RAM_PTR, 8'h10};
    foreach (idx[i]) begin
      bus(1'b0, idx[i], 8'h00);
      check(rd_val, REG_RESET);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    bus(1'b1, IDX_ADDR_LOW, 8'ha5);
    bus(1'b1, IDX_ADDR_HIGH, 8'h3c);
    bus(1'b1, IDX_RAM_PTR, 8'h96);
    bus(1'b1, 8'h10, 8'h77);
    avs_byteenable <= 4'he;
    bus(1'b1, IDX_ADDR_LOW, 8'h11);
    avs_byteenable <= 4'hf;
    bus(1'b0, IDX_ADDR_LOW, 8'h00);
    check(rd_val, 8'ha5);
    bus(1'b0, IDX_ADDR_HIGH, 8'h00);
    check(rd_val, 8'h3c);
    bus(1'b0, IDX_RAM_PTR, 8'h00);
    check(rd_val, 8'h96);
    bus(1'b0, 8'h10, 8'h00);
    check(rd_val, 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_page(input logic [7:0] ptr, input logic [15:0] ad, input logic [3:0] lg);
    logic [11:0] base;
    base = ad[11:0] & 12'hfe0;
    lag <= lg;
    for (int k = 0; k < 32; k++) i_flash_partner.ram[8'(ptr + k)] = 8'(k * 7) ^ ptr;
    bus(1'b1, IDX_ADDR_LOW, ad[7:0]);
    bus(1'b1, IDX_ADDR_HIGH, ad[15:8]);
    bus(1'b1, IDX_RAM_PTR, ptr);
    nwr = 0;
    bus(1'b1, IDX_COMMAND, CMD_PAGE);
    repeat (2) @(posedge clk);
    check(fetch_stall, 1'b1);
    bus(1'b0, IDX_RAM_PTR, 8'h00);
    check(nwr, 32);
    check(rd_val, ptr);
    check(fetch_stall, 1'b0);
    for (int k = 0; k < 32; k++) begin
      check(wr_log[k], base + 12'(k));
      check(i_flash_partner.flash[base + 12'(k)], 8'(k * 7) ^ ptr);
    end
    check(i_flash_partner.flash[base + 12'h020], 8'hff);
    check(i_flash_partner.flash[base - 12'h001], 8'hff);
    $display("test page done");
  endtask : t_page

  task automatic t_byte(input logic [15:0] ad, input logic [7:0] d);
    lag <= 4'h1;
    i_flash_partner.ram[8'h61] = d;
    i_flash_partner.ram[8'h62] = ~d;
    bus(1'b1, IDX_ADDR_LOW, ad[7:0]);
    bus(1'b1, IDX_ADDR_HIGH, ad[15:8]);
    bus(1'b1, IDX_RAM_PTR, 8'h61);
    nwr = 0;
    bus(1'b1, IDX_COMMAND, CMD_BYTE);
    repeat (2) @(posedge clk);
    bus(1'b0, IDX_STATUS, 8'h00);
    check(rd_val, 8'h00);
    check(nwr, 1);
    check(wr_log[0], ad[11:0]);
    check(i_flash_partner.flash[ad[11:0]], d);
    check(i_flash_partner.flash[ad[11:0] + 12'h001], 8'hff);
    $display("test byte done");
  endtask : t_byte

  task automatic t_bad;
    nwr = 0;
    bus(1'b1, IDX_COMMAND, 8'h33);
    repeat (4) @(posedge clk);
    bus(1'b0, IDX_STATUS, 8'h00);
    check(rd_val, 8'h02);
    check(nwr, 0);
    check(fetch_stall, 1'b0);
    $display("test bad command done");
  endtask : t_bad

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  initial begin
    {avs_read, avs_write, nwr, errors, samples_checked} = '0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    lag = 4'h1;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_regs;
    t_page(8'h60, 16'h0fc7, 4'h3);
    t_page(8'hf0, 16'h0100, 4'h1);
    t_bad;
    t_byte(16'h0855, 8'hc3);
    finish_test;
  end
  initial begin
    #(40 * 20000);
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
endmodule : flash_self_program_sequencer_test
